// ===== design/call_transfer_checker.sv
`timescale 1ns/1ps
module call_transfer_checker
   import call_pkg::*;
#(
   parameter int VA_BITS = 48
)
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire req_t req_i,
   output logic desc_req_o,
   output logic [15:0] desc_sel_o,
   input wire logic desc_valid_i,
   input wire desc_t desc_i,
   output logic push_valid_o,
   output logic [63:0] push_data_o,
   output logic [3:0] push_bytes_o,
   input wire logic push_ready_i,
   output logic done_o,
   output logic upd_o,
   output flt_t flt_o,
   output logic [15:0] flt_code_o,
   output path_t path_o,
   output logic [15:0] new_cs_o,
   output logic [63:0] new_ip_o,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   output logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   input wire logic [AXI_AW-1:0] s_axi_araddr_i,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o
);

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_EVAL = 3'b001,
      S_DESC = 3'b010,
      S_CHK = 3'b011,
      S_GDESC = 3'b100,
      S_PUSH_CS = 3'b101,
      S_PUSH_IP = 3'b110
   } fsm_t;

   typedef struct packed {
      fsm_t fsm;
      req_t rq;
      desc_t ds;
      logic [15:0] dsel;
      logic [63:0] pd;
      logic [3:0] pb;
      logic [63:0] ipd;
      logic [3:0] ipb;
      logic [15:0] ncs;
      logic [63:0] nip;
      logic [15:0] ocs;
      logic [63:0] oip;
      logic done;
      logic upd;
      flt_t flt;
      logic [15:0] code;
      path_t path;
      logic en;
      logic [15:0] ncall;
      logic [15:0] nflt;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
   } st_t;

   st_t st_r;
   st_t st_nxt;
   logic fin;
   flt_t fv;
   logic [15:0] cv;
   logic [7:0] need;
   logic [31:0] rdv;
   logic [63:0] nr_in;
   logic [63:0] nr_tgt;
   logic nr_lim;
   logic [63:0] fr_tgt;
   logic fr_lim;
   logic fr_can;
   logic is_code;
   logic is_gate;
   logic is_task;
   logic real_md;

   // old pointer cut to the operand size before it is pushed
   function automatic logic [63:0] ipmask(input osz_t o, input logic [63:0] ip);
      case (o)
         OS16: ipmask = {48'h0, ip[15:0]};
         OS32: ipmask = {32'h0, ip[31:0]};
         default: ipmask = ip;
      endcase
   endfunction

   function automatic logic [3:0] pbytes(input osz_t o);
      case (o)
         OS16: pbytes = PB16;
         OS32: pbytes = PB32;
         default: pbytes = PB64;
      endcase
   endfunction

   // index test covers the whole 8-byte descriptor, not only its first byte
   function automatic logic sel_out(input logic [15:0] s, input req_t r);
      sel_out = {s[15:3], 3'b111} > (s[2] ? r.ldt_lim : r.gdt_lim);
   endfunction

   // near targets: relative adds the sign-extended rel32, absolute takes the operand
   assign nr_in = (st_r.rq.kind == K_NREL) ?
      st_r.rq.ip + {{32{st_r.rq.dest[31]}}, st_r.rq.dest[31:0]} : st_r.rq.dest; // R01
   assign real_md = !st_r.rq.pe || st_r.rq.vm;

   target_check #(.VA_BITS(VA_BITS)) u_near (
      .target_i(nr_in),
      .os16_i(st_r.rq.osz == OS16),
      .mask32_i(st_r.rq.osz != OS64),
      .limit_i(st_r.rq.cs_lim),
      .chk_limit_i(st_r.rq.osz != OS64),
      .chk_canon_i(1'b0),
      .tgt_o(nr_tgt),
      .lim_flt_o(nr_lim),
      .canon_flt_o()
   );

   // compatibility target when long mode is on and the new segment is not long
   target_check #(.VA_BITS(VA_BITS)) u_far (
      .target_i(st_r.rq.dest),
      .os16_i(st_r.rq.osz == OS16),
      .mask32_i(st_r.rq.lma && !st_r.ds.l),
      .limit_i(st_r.ds.limit),
      .chk_limit_i(!st_r.rq.lma || !st_r.ds.l),
      .chk_canon_i(1'b1),
      .tgt_o(fr_tgt),
      .lim_flt_o(fr_lim),
      .canon_flt_o(fr_can)
   );

   // descriptor classes allowed depend on long mode
   always_comb
   begin
      is_code = st_r.ds.s && st_r.ds.typ[3];
      if (st_r.rq.lma)
      begin
         is_gate = !st_r.ds.s && (st_r.ds.typ == T_CGATE64); // R10
         is_task = 1'b0; // R10
      end
      else
      begin
         is_gate = !st_r.ds.s && (st_r.ds.typ[2:0] == T_CGATE_LO); // R09
         is_task = !st_r.ds.s && ((st_r.ds.typ == T_TGATE) ||
            (!st_r.ds.typ[2] && st_r.ds.typ[0])); // R09
      end
   end

   // whole next state; all fault checks end before the first push
   always_comb
   begin
      st_nxt = st_r;
      fin = 1'b0;
      fv = F_NONE;
      cv = 16'h0000;
      need = ROOM_FAR64;
      rdv = 32'h0;
      st_nxt.done = 1'b0;
      st_nxt.upd = 1'b0;
      case (st_r.rq.osz)
         OS16: need = ROOM_FAR16;
         OS32: need = ROOM_FAR32;
         default: need = ROOM_FAR64;
      endcase
      case (st_r.fsm)
         S_IDLE:
            if (req_valid_i && st_r.en)
            begin
               st_nxt.rq = req_i;
               st_nxt.path = P_NONE;
               st_nxt.fsm = S_EVAL;
            end
         S_EVAL:
            if (st_r.rq.kind != K_FAR)
            begin
               fin = 1'b1;
               if (st_r.rq.osz != OS64 && nr_lim)
                  fv = F_GP; // R02 R03 R05
               else if (st_r.rq.osz == OS64 && st_r.rq.room < ROOM_NEAR64)
                  fv = F_SS; // R01 R04
               else if (st_r.rq.osz == OS32 && st_r.rq.room < ROOM_NEAR32)
                  fv = F_SS; // R02 R05
               else if (st_r.rq.osz == OS16 && st_r.rq.room < ROOM_NEAR16)
                  fv = F_SS; // R03 R05
               else
               begin
                  fin = 1'b0;
                  st_nxt.pd = ipmask(st_r.rq.osz, st_r.rq.ip); // R01 R03
                  st_nxt.pb = pbytes(st_r.rq.osz);
                  st_nxt.ncs = st_r.rq.cs;
                  st_nxt.nip = nr_tgt; // R04
                  st_nxt.fsm = S_PUSH_IP;
               end
            end
            else if (real_md && st_r.rq.osz == OS32)
            begin
               fin = 1'b1;
               if (st_r.rq.room < ROOM_REAL32)
                  fv = F_SS; // R06
               else if (st_r.rq.dest[31:16] != 16'h0)
                  fv = F_GP; // R06
               else
               begin
                  fin = 1'b0;
                  st_nxt.pd = {48'h0, st_r.rq.cs}; // R06
                  st_nxt.pb = PB32;
                  st_nxt.ipd = {32'h0, st_r.rq.ip[31:0]};
                  st_nxt.ipb = PB32;
                  st_nxt.ncs = st_r.rq.dest[47:32]; // R06
                  st_nxt.nip = {32'h0, st_r.rq.dest[31:0]};
                  st_nxt.fsm = S_PUSH_CS;
               end
            end
            else if (real_md)
            begin
               if (st_r.rq.room < ROOM_REAL16)
               begin
                  fin = 1'b1;
                  fv = F_SS; // R07
               end
               else
               begin
                  st_nxt.pd = {48'h0, st_r.rq.cs}; // R07
                  st_nxt.pb = PB16;
                  st_nxt.ipd = {48'h0, st_r.rq.ip[15:0]};
                  st_nxt.ipb = PB16;
                  st_nxt.ncs = st_r.rq.dest[31:16]; // R07
                  st_nxt.nip = {48'h0, st_r.rq.dest[15:0]}; // R07
                  st_nxt.fsm = S_PUSH_CS;
               end
            end
            else if (st_r.rq.sel[15:2] == 14'h0)
            begin
               fin = 1'b1;
               fv = F_GP; // R08
            end
            else if (sel_out(st_r.rq.sel, st_r.rq))
            begin
               fin = 1'b1;
               fv = F_GP; // R08
               cv = st_r.rq.sel;
            end
            else
            begin
               st_nxt.dsel = st_r.rq.sel;
               st_nxt.fsm = S_DESC;
            end
         S_DESC:
            if (desc_valid_i)
            begin
               st_nxt.ds = desc_i;
               st_nxt.fsm = S_CHK;
            end
         S_CHK:
         begin
            fin = 1'b1;
            if (is_code)
            begin
               if (st_r.rq.lma && st_r.ds.l && st_r.ds.d)
               begin
                  fv = F_GP; // R11 R12
                  cv = st_r.rq.sel;
               end
               else if (st_r.ds.typ[2] ? (st_r.ds.descriptor_privilege > st_r.rq.current_privilege) :
                  ((st_r.rq.sel[1:0] > st_r.rq.current_privilege) || (st_r.ds.descriptor_privilege != st_r.rq.current_privilege)))
               begin
                  fv = F_GP; // R11 R12
                  cv = st_r.rq.sel;
               end
               else if (!st_r.ds.p)
               begin
                  fv = F_NP; // R11 R12
                  cv = st_r.rq.sel;
               end
               else if (st_r.rq.room < need)
                  fv = F_SS; // R13
               else if (fr_lim || fr_can)
                  fv = F_GP; // R15
               else
               begin
                  fin = 1'b0;
                  st_nxt.pd = {48'h0, st_r.rq.cs}; // R16
                  st_nxt.pb = pbytes(st_r.rq.osz);
                  st_nxt.ipd = ipmask(st_r.rq.osz, st_r.rq.ip);
                  st_nxt.ipb = pbytes(st_r.rq.osz);
                  st_nxt.ncs = {st_r.rq.sel[15:2], st_r.rq.current_privilege}; // R16
                  st_nxt.nip = fr_tgt; // R14
                  st_nxt.fsm = S_PUSH_CS;
               end
            end
            else if (is_gate)
            begin
               if ((st_r.ds.descriptor_privilege < st_r.rq.current_privilege) || (st_r.rq.sel[1:0] > st_r.ds.descriptor_privilege))
               begin
                  fv = F_GP; // R17
                  cv = st_r.rq.sel;
               end
               else if (!st_r.ds.p)
               begin
                  fv = F_NP; // R17
                  cv = st_r.rq.sel;
               end
               else if (st_r.ds.gsel[15:2] == 14'h0)
                  fv = F_GP; // R18
               else if (sel_out(st_r.ds.gsel, st_r.rq))
               begin
                  fv = F_GP; // R18
                  cv = st_r.ds.gsel;
               end
               else
               begin
                  fin = 1'b0;
                  st_nxt.dsel = st_r.ds.gsel;
                  st_nxt.fsm = S_GDESC;
               end
            end
            else if (is_task)
               st_nxt.path = P_TASK; // hand-off, no switch here
            else
            begin
               fv = F_GP; // R09 R10
               cv = st_r.rq.sel;
            end
         end
         S_GDESC:
            if (desc_valid_i)
            begin
               fin = 1'b1;
               if (!(desc_i.s && desc_i.typ[3]) || (desc_i.descriptor_privilege > st_r.rq.current_privilege))
               begin
                  fv = F_GP; // R19
                  cv = st_r.ds.gsel;
               end
               else if (!desc_i.typ[2] && (desc_i.descriptor_privilege < st_r.rq.current_privilege))
                  st_nxt.path = P_MORE; // R20
               else
                  st_nxt.path = P_SAME; // R20
            end
         S_PUSH_CS:
            if (push_ready_i)
            begin
               st_nxt.pd = st_r.ipd; // R16
               st_nxt.pb = st_r.ipb;
               st_nxt.fsm = S_PUSH_IP;
            end
         S_PUSH_IP:
            if (push_ready_i)
            begin
               fin = 1'b1;
               st_nxt.upd = 1'b1;
               st_nxt.ocs = st_r.ncs;
               st_nxt.oip = st_r.nip;
            end
         default:
            st_nxt.fsm = S_IDLE;
      endcase
      // a fault never touches the visible segment and pointer
      if (fin)
      begin
         st_nxt.fsm = S_IDLE;
         st_nxt.done = 1'b1;
         st_nxt.flt = fv; // R21
         st_nxt.code = cv; // R21
         st_nxt.ncall = st_r.ncall + 16'h1;
         if (fv != F_NONE)
            st_nxt.nflt = st_r.nflt + 16'h1;
      end
      // register write: address and data are taken together
      if (!st_r.bv && s_axi_awvalid_i && s_axi_wvalid_i)
      begin
         st_nxt.bv = 1'b1;
         st_nxt.br = RESP_OKAY;
         if (s_axi_awaddr_i == A_CTRL)
         begin
            if (s_axi_wstrb_i[0])
               st_nxt.en = s_axi_wdata_i[CTRL_EN_BIT];
         end
         else if (s_axi_awaddr_i[1:0] != 2'b00)
            st_nxt.br = RESP_SLVERR;
      end
      else if (st_r.bv && s_axi_bready_i)
         st_nxt.bv = 1'b0;
      // register read
      if (!st_r.rv && s_axi_arvalid_i)
      begin
         st_nxt.rv = 1'b1;
         st_nxt.rr = RESP_OKAY;
         case (s_axi_araddr_i)
            A_CTRL: rdv[CTRL_EN_BIT] = st_r.en;
            A_STAT:
            begin
               rdv[ST_BUSY] = (st_r.fsm != S_IDLE);
               rdv[ST_FLT +: 2] = st_r.flt;
               rdv[ST_PATH +: 2] = st_r.path;
               rdv[ST_CODE +: 16] = st_r.code;
            end
            A_CALLS: rdv = {16'h0, st_r.ncall};
            A_FLTS: rdv = {16'h0, st_r.nflt};
            default: st_nxt.rr = RESP_SLVERR;
         endcase
         st_nxt.rd = rdv;
      end
      else if (st_r.rv && s_axi_rready_i)
         st_nxt.rv = 1'b0;
   end

   // clearing the enable only stops new requests, a call under way completes
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         st_r <= '0;
         st_r.en <= CTRL_EN_RST;
      end
      else
         st_r <= st_nxt;
   end

   assign req_ready_o = (st_r.fsm == S_IDLE) && st_r.en;
   assign desc_req_o = (st_r.fsm == S_DESC) || (st_r.fsm == S_GDESC);
   assign desc_sel_o = st_r.dsel;
   assign push_valid_o = (st_r.fsm == S_PUSH_CS) || (st_r.fsm == S_PUSH_IP);
   assign push_data_o = st_r.pd;
   assign push_bytes_o = st_r.pb;
   assign done_o = st_r.done;
   assign upd_o = st_r.upd;
   assign flt_o = st_r.flt;
   assign flt_code_o = st_r.code;
   assign path_o = st_r.path;
   assign new_cs_o = st_r.ocs;
   assign new_ip_o = st_r.oip;
   assign s_axi_awready_o = !st_r.bv && s_axi_awvalid_i && s_axi_wvalid_i;
   assign s_axi_wready_o = !st_r.bv && s_axi_awvalid_i && s_axi_wvalid_i;
   assign s_axi_bvalid_o = st_r.bv;
   assign s_axi_bresp_o = st_r.br;
   assign s_axi_arready_o = !st_r.rv;
   assign s_axi_rvalid_o = st_r.rv;
   assign s_axi_rdata_o = st_r.rd;
   assign s_axi_rresp_o = st_r.rr;

   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   logic e_near;
   logic e_far;
   assign e_near = (st_r.fsm == S_EVAL) && (st_r.rq.kind != K_FAR);
   assign e_far = (st_r.fsm == S_EVAL) && (st_r.rq.kind == K_FAR);

   a_near64_room: assert property ( // R01
      e_near && st_r.rq.osz == OS64 && st_r.rq.room < ROOM_NEAR64
      |=> done_o && flt_o == F_SS && flt_code_o == 16'h0 && !upd_o)
      else $error("near 64 call without room not faulted");
   a_near32_limit: assert property ( // R02
      e_near && st_r.rq.osz == OS32 && nr_lim |=> done_o && flt_o == F_GP)
      else $error("near 32 limit fault missing");
   a_near16_mask: assert property ( // R03
      done_o && upd_o && st_r.rq.kind != K_FAR && st_r.rq.osz == OS16
      |-> new_ip_o[63:16] == 48'h0)
      else $error("near 16 target not masked");
   a_near_abs64: assert property ( // R04
      e_near && st_r.rq.kind == K_NABS && st_r.rq.osz == OS64 &&
      st_r.rq.room >= ROOM_NEAR64
      |=> push_valid_o && push_bytes_o == PB64 && st_r.nip == $past(st_r.rq.dest))
      else $error("near absolute 64 target wrong");
   a_real32_high: assert property ( // R06
      e_far && real_md && st_r.rq.osz == OS32 && st_r.rq.room >= ROOM_REAL32 &&
      st_r.rq.dest[31:16] != 16'h0 |=> done_o && flt_o == F_GP)
      else $error("real far 32 high offset not faulted");
   a_real16_push: assert property ( // R07
      e_far && real_md && st_r.rq.osz == OS16 && st_r.rq.room >= ROOM_REAL16
      |=> push_valid_o && push_bytes_o == PB16 && push_data_o[15:0] == $past(st_r.rq.cs))
      else $error("real far 16 segment push wrong");
   a_null_sel: assert property ( // R08
      e_far && !real_md && st_r.rq.sel[15:2] == 14'h0
      |=> done_o && flt_o == F_GP && flt_code_o == 16'h0)
      else $error("null selector not faulted");
   a_lm_type: assert property ( // R10
      st_r.fsm == S_CHK && st_r.rq.lma && !st_r.ds.s && st_r.ds.typ != T_CGATE64
      |=> done_o && flt_o == F_GP && flt_code_o == $past(st_r.rq.sel))
      else $error("long mode bad descriptor accepted");
   a_rpl_forced: assert property ( // R16
      done_o && upd_o && st_r.rq.kind == K_FAR && st_r.rq.pe && !st_r.rq.vm
      |-> new_cs_o[1:0] == st_r.rq.current_privilege)
      else $error("far call privilege not forced");
   a_gate_more: assert property ( // R20
      st_r.fsm == S_GDESC && desc_valid_i && desc_i.s && desc_i.typ[3] &&
      !desc_i.typ[2] && desc_i.descriptor_privilege < st_r.rq.current_privilege
      |=> done_o && path_o == P_MORE && flt_o == F_NONE)
      else $error("gate path not more privilege");
   a_fault_hold: assert property ( // R21
      done_o && flt_o != F_NONE |-> !upd_o && $stable(new_ip_o) && $stable(new_cs_o))
      else $error("fault changed visible state");

   c_near_ok: cover property (e_near ##[1:20] done_o && upd_o);
   c_real_ok: cover property (e_far && real_md ##[1:20] done_o && upd_o);
   c_gate: cover property (st_r.fsm == S_GDESC ##[1:20] done_o && path_o != P_NONE);
   c_stack: cover property (done_o && flt_o == F_SS);

endmodule // call_transfer_checker

// ===== design/target_check.sv
`timescale 1ns/1ps
module target_check
   import call_pkg::*;
#(
   parameter int VA_BITS = 48
)
(
   input wire logic [63:0] target_i,
   input wire logic os16_i,
   input wire logic mask32_i,
   input wire logic [31:0] limit_i,
   input wire logic chk_limit_i,
   input wire logic chk_canon_i,
   output logic [63:0] tgt_o,
   output logic lim_flt_o,
   output logic canon_flt_o
);

   logic [63:0] t32;

   // masking first, so limit and canonical checks see the final offset
   always_comb
   begin
      t32 = mask32_i ? {32'h0, target_i[31:0]} : target_i; // R14
      tgt_o = os16_i ? {48'h0, t32[15:0]} : t32; // R14
   end

   // upper bits must all copy the top implemented bit
   assign lim_flt_o = chk_limit_i && (tgt_o > {32'h0, limit_i}); // R15
   assign canon_flt_o = chk_canon_i &&
      !((&tgt_o[63:VA_BITS-1]) || !(|tgt_o[63:VA_BITS-1])); // R15

endmodule // target_check

// ===== shared/call_pkg.sv
// Behaviour
// R01 - near relative 64: sign-extend, 8-byte room, push
// R02 - near relative 32: limit check, 4-byte room
// R03 - near relative 16: mask 16 bits, limit, 2-byte room
// R04 - near absolute 64: no limit check, 8-byte room
// R05 - near absolute 32/16: mask, limit, room check
// R06 - real far 32: 6 bytes, high offset zero
// R07 - real far 16: 4 bytes, load segment, pointer
// R08 - protected far: null or out-of-table selector faults
// R09 - legacy mode: only code, gates, task segments
// R10 - long mode: only code or 64-bit gate
// R11 - conforming code: long/default bits, privilege, present
// R12 - nonconforming code: requested and descriptor privilege match (code: requested <= current, descriptor == current)
// R13 - far code: stack room before offset
// R14 - far code: offset masked to 32/16 bits
// R15 - far code: limit and canonical offset faults
// R16 - far code: push segment, pointer, force privilege
// R17 - call gate: privilege and present checks
// R18 - gate code selector null or outside tables
// R19 - gate target must be code, privilege ok
// R20 - pick more or same privilege path
// R21 - report fault class and code, no update
package call_pkg;

   typedef enum logic [1:0] {K_NREL = 2'b00, K_NABS = 2'b01, K_FAR = 2'b10} kind_t;
   typedef enum logic [1:0] {OS16 = 2'b00, OS32 = 2'b01, OS64 = 2'b10} osz_t;
   typedef enum logic [1:0] {F_NONE = 2'b00, F_GP = 2'b01, F_SS = 2'b10, F_NP = 2'b11} flt_t;
   typedef enum logic [1:0] {P_NONE = 2'b00, P_SAME = 2'b01, P_MORE = 2'b10, P_TASK = 2'b11} path_t;

   // stack room needed, in bytes
   localparam logic [7:0] ROOM_NEAR64 = 8'h08;
   localparam logic [7:0] ROOM_NEAR32 = 8'h04;
   localparam logic [7:0] ROOM_NEAR16 = 8'h02;
   localparam logic [7:0] ROOM_REAL32 = 8'h06;
   localparam logic [7:0] ROOM_REAL16 = 8'h04;
   localparam logic [7:0] ROOM_FAR64 = 8'h10;
   localparam logic [7:0] ROOM_FAR32 = 8'h08;
   localparam logic [7:0] ROOM_FAR16 = 8'h04;
   // push widths in bytes
   localparam logic [3:0] PB16 = 4'h2;
   localparam logic [3:0] PB32 = 4'h4;
   localparam logic [3:0] PB64 = 4'h8;
   // system descriptor types
   localparam logic [3:0] T_CGATE64 = 4'hc;
   localparam logic [2:0] T_CGATE_LO = 3'b100;
   localparam logic [3:0] T_TGATE = 4'h5;
   // register map
   localparam int AXI_AW = 4;
   localparam logic [AXI_AW-1:0] A_CTRL = 4'h0;
   localparam logic [AXI_AW-1:0] A_STAT = 4'h4;
   localparam logic [AXI_AW-1:0] A_CALLS = 4'h8;
   localparam logic [AXI_AW-1:0] A_FLTS = 4'hc;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int ST_BUSY = 0;
   localparam int ST_FLT = 1;
   localparam int ST_PATH = 3;
   localparam int ST_CODE = 16;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      kind_t kind;
      osz_t osz;
      logic pe;
      logic vm;
      logic lma;
      logic [1:0] current_privilege;
      logic [15:0] cs;
      logic [63:0] ip;
      logic [31:0] cs_lim;
      logic [63:0] dest;
      logic [15:0] sel;
      logic [7:0] room;
      logic [15:0] gdt_lim;
      logic [15:0] ldt_lim;
   } req_t;

   typedef struct packed {
      logic s;
      logic [3:0] typ;
      logic [1:0] descriptor_privilege;
      logic p;
      logic l;
      logic d;
      logic [31:0] limit;
      logic [15:0] gsel;
   } desc_t;

endpackage

// ===== testbench/mem_model.sv
`timescale 1ns/1ps
module mem_model
   import call_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic desc_req_i,
   input wire desc_t cfg_i,
   input wire logic push_valid_i,
   output logic desc_valid_o = 1'b0,
   output desc_t desc_o,
   output logic push_ready_o = 1'b0
);
   logic dly_r = 1'b0;
   // descriptor two cycles late, each push one cycle late
   always_ff @(posedge core_clk_i)
   begin
      dly_r <= desc_req_i && !dly_r && !desc_valid_o;
      desc_valid_o <= dly_r;
      push_ready_o <= push_valid_i && !push_ready_o;
   end
   // inverted data outside the pulse, so a stale read never matches
   assign desc_o = desc_valid_o ? cfg_i : ~cfg_i;
endmodule // mem_model

// ===== testbench/test_call_transfer_checker.sv
`timescale 1ns/1ps
module test_call_transfer_checker
   import call_pkg::*;
;
   logic clk = 1'b0, rst_b = 1'b0, rv = 1'b0, awv = 1'b0, arv = 1'b0, bq = 1'b0, rrq = 1'b0;
   logic rdy, dq, dv, pv, pr, done, upd, awr, wr, bv, arr, rvl;
   logic [15:0] dsel, code, ncs;
   logic [63:0] pd, nip;
   logic [3:0] pb, aa = 4'h0, ra = 4'h0;
   logic [31:0] wd = 32'h0, rd;
   logic [1:0] br, rr;
   flt_t flt;
   path_t path;
   req_t rq = '0;
   desc_t dd, cf = '0;
   logic [67:0] pq[$];
   int err_count = 0, cmp_count = 0, tn = 0;
   call_transfer_checker call_transfer_checker_i (.core_clk_i(clk), .rst_b_i(rst_b),
      .req_valid_i(rv), .req_ready_o(rdy), .req_i(rq), .desc_req_o(dq), .desc_sel_o(dsel),
      .desc_valid_i(dv), .desc_i(dd), .push_valid_o(pv), .push_data_o(pd), .push_bytes_o(pb),
      .push_ready_i(pr), .done_o(done), .upd_o(upd), .flt_o(flt), .flt_code_o(code),
      .path_o(path), .new_cs_o(ncs), .new_ip_o(nip), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_awaddr_i(aa), .s_axi_wvalid_i(awv), .s_axi_wready_o(wr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(bq),
      .s_axi_bresp_o(br), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ra),
      .s_axi_rvalid_o(rvl), .s_axi_rready_i(rrq), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr));
   mem_model mem_model_i (.core_clk_i(clk), .desc_req_i(dq), .cfg_i(cf), .push_valid_i(pv),
      .desc_valid_o(dv), .desc_o(dd), .push_ready_o(pr));
   // clock and watchdog
   initial
      forever #5 clk = ~clk;
   initial
   begin
      #200000;
      err_count++;
      finish_test();
   end
   // log every push the stack side accepts
   always @(posedge clk)
      if (pv && pr)
         pq.push_back({pb, pd});
   task automatic chk(input logic [151:0] s, input logic [151:0] e);
      cmp_count++;
      if (s !== e)
      begin
         err_count++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   // one call: hold request until taken, then await done
   task automatic run(input kind_t k, input osz_t o, input logic [1:0] m, input logic [63:0] ip,
         input logic [63:0] d, input logic [15:0] s, input logic [7:0] b, input flt_t ef,
         input logic [15:0] ec, input logic [63:0] ei);
      @(posedge clk);
      rq.kind <= k;
      rq.osz <= o;
      {rq.pe, rq.lma} <= m;
      {rq.ip, rq.dest, rq.sel, rq.room} <= {ip, d, s, b};
      rv <= 1'b1;
      pq.delete();
      do @(negedge clk); while (rdy !== 1'b1);
      @(posedge clk) rv <= 1'b0;
      do @(negedge clk); while (done !== 1'b1);
      chk({upd, flt, code}, {ef == F_NONE, ef, ec});
      if (ef == F_NONE)
         chk(nip, ei);
      tn++;
      $display("call test %0d done", tn);
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge clk);
      {awv, aa, wd, bq} <= {1'b1, a, d, 1'b1};
      do @(negedge clk); while (awr !== 1'b1);
      @(posedge clk) awv <= 1'b0;
      do @(negedge clk); while (bv !== 1'b1);
      chk(br, e);
      @(posedge clk) bq <= 1'b0;
   endtask
   task automatic axr(input logic [3:0] a, input logic [33:0] e);
      @(posedge clk);
      {arv, ra, rrq} <= {1'b1, a, 1'b1};
      do @(negedge clk); while (arr !== 1'b1);
      @(posedge clk) arv <= 1'b0;
      do @(negedge clk); while (rvl !== 1'b1);
      chk({rr, rd}, e);
      @(posedge clk) rrq <= 1'b0;
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // fixed segment state; conforming code descriptor first
   initial
   begin
      {rq.cs, rq.cs_lim, rq.gdt_lim, rq.ldt_lim} = {16'h0008, 32'hffff, 16'hff, 16'hff};
      {cf.s, cf.typ, cf.p, cf.d, cf.limit} = {1'b1, 4'he, 1'b1, 1'b1, 32'hffff_ffff};
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      axr(A_CTRL, {RESP_OKAY, 32'h1});
      run(K_NREL, OS64, 2'h3, 64'h1_0000_1000, 64'hffff_fff0, 16'h0, 8'h8, F_NONE, 16'h0,
         64'h1_0000_0ff0);
      chk(pq[0], {4'h8, 64'h1_0000_1000});
      run(K_NREL, OS64, 2'h3, 64'h1000, 64'h10, 16'h0, 8'h7, F_SS, 16'h0, 64'h0);
      run(K_NABS, OS64, 2'h3, 64'h0, 64'h7fff_0000_0000, 16'h0, 8'h8, F_NONE, 16'h0,
         64'h7fff_0000_0000);
      run(K_NREL, OS32, 2'h2, 64'hfff0, 64'h20, 16'h0, 8'h4, F_GP, 16'h0, 64'h0);
      run(K_NREL, OS16, 2'h2, 64'hfff0, 64'h20, 16'h0, 8'h2, F_NONE, 16'h0, 64'h10);
      chk(pq[0], {4'h2, 64'hfff0});
      run(K_NABS, OS16, 2'h2, 64'h0, 64'h3_1234, 16'h0, 8'h2, F_NONE, 16'h0, 64'h1234);
      run(K_FAR, OS16, 2'h2, 64'h0, 64'h0, 16'h3, 8'h4, F_GP, 16'h0, 64'h0);
      run(K_FAR, OS16, 2'h2, 64'h0, 64'h0, 16'h100, 8'h4, F_GP, 16'h100, 64'h0);
      run(K_FAR, OS32, 2'h2, 64'h200, 64'h4000, 16'h13, 8'h8, F_NONE, 16'h0, 64'h4000);
      chk({ncs, pq[0], pq[1]}, {16'h10, 4'h4, 64'h8, 4'h4, 64'h200});
      run(K_FAR, OS16, 2'h2, 64'h0, 64'h1_2345, 16'h10, 8'h4, F_NONE, 16'h0, 64'h2345);
      run(K_FAR, OS32, 2'h2, 64'h0, 64'h0, 16'h10, 8'h7, F_SS, 16'h0, 64'h0);
      cf.p = 1'b0;
      run(K_FAR, OS32, 2'h2, 64'h0, 64'h0, 16'h10, 8'h8, F_NP, 16'h10, 64'h0);
      {cf.p, cf.typ, cf.descriptor_privilege} = {1'b1, 4'ha, 2'h1};
      run(K_FAR, OS32, 2'h2, 64'h0, 64'h0, 16'h10, 8'h8, F_GP, 16'h10, 64'h0);
      cf.typ = 4'h2;
      run(K_FAR, OS32, 2'h2, 64'h0, 64'h0, 16'h10, 8'h8, F_GP, 16'h10, 64'h0);
      {cf.s, cf.typ} = 5'h0c;
      run(K_FAR, OS32, 2'h2, 64'h0, 64'h0, 16'h10, 8'h8, F_GP, 16'h0, 64'h0);
      run(K_FAR, OS32, 2'h0, 64'h0, 64'h20_0001_0000, 16'h0, 8'h6, F_GP, 16'h0, 64'h0);
      run(K_FAR, OS16, 2'h0, 64'h200, 64'h1234_0100, 16'h0, 8'h4, F_NONE, 16'h0, 64'h100);
      chk({ncs, pq[0], pq[1]}, {16'h1234, 4'h2, 64'h8, 4'h2, 64'h200});
      // disabled block refuses calls; misaligned accesses are errors
      axw(A_CTRL, 32'h0, RESP_OKAY);
      @(negedge clk) chk(rdy, 1'b0);
      axw(A_CTRL, 32'h1, RESP_OKAY);
      axw(4'h1, 32'h0, RESP_SLVERR);
      axr(4'h2, {RESP_SLVERR, 32'h0});
      axr(A_FLTS, {RESP_OKAY, 32'ha});
      finish_test();
   end
endmodule // test_call_transfer_checker
